/* File: core/dpkr_core.sv */
`timescale 1ns/1ps
`include "dpkr_cfg.svh"
module dpkr_core
  import dpkr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        key_start,
  input  wire logic        key_info_flag,
  input  wire logic [1:0]  key_size,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  input  wire logic        bit_tick,
  input  wire logic [2:0]  guard_bits,
  input  wire logic        interbyte_delay_enable,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        repeat_load,
  input  wire logic [7:0]  repeat_count_value,
  input  wire logic        instr_done,
  input  wire logic        break_seen,
  output logic             repeat_active,
  output logic             repeat_reissue,
  input  wire logic        port_disable,
  input  wire logic        lockbits_set,
  input  wire logic        prog_done,
  input  wire logic        urow_status_write,
  input  wire logic        erase_done,
  input  wire logic [2:0]  bod_fuse_level,
  output logic [2:0]       key_state_reg,
  output logic             lock_state_flag,
  output logic             sysbus_allow,
  output logic             brownout_force,
  output logic [2:0]       brownout_level,
  input  wire logic [55:0] family_identifier,
  input  wire logic [23:0] memory_ctrl_version,
  input  wire logic [23:0] debug_logic_version,
  input  wire logic [7:0]  debug_osc_frequency
);
  dpkr_state_e  st_reg, st_next;
  logic [63:0]  key_sh_reg, key_sh_next;
  logic [3:0]   kcnt_reg, kcnt_next;
  logic [4:0]   bidx_reg, bidx_next, blen_reg, blen_next;
  logic [2:0]   wait_reg, wait_next;
  logic [2:0]   key_next, lvl_next;
  logic [7:0]   rpt_reg, rpt_next;
  logic         ract_next, erasing_reg, erasing_next;
  logic [127:0] system_info_block;
  logic         f_valid, f_ready, push;
  logic [7:0]   f_data;

  // info block assembled byte 0 lowest; ascii content fed by straps
  assign system_info_block = {debug_osc_frequency, 8'h00, debug_logic_version, memory_ctrl_version, 8'h00, family_identifier};

  function automatic logic [7:0] sib_byte(input logic [127:0] b, input logic [4:0] i);
    sib_byte = b[{i[3:0], 3'h0} +: 8];
  endfunction

  // info block byte count from the size field; only 64-bit keys are legal
  function automatic logic [4:0] frame_len(input logic [1:0] sz);
    frame_len = (sz == `DPKR_SIZE_128) ? `DPKR_SIB_FULL_BYTES : `DPKR_SIB_HALF_BYTES;
  endfunction

  assign push = (st_reg == DPKR_SEND) && f_ready;

  // key reception, info readout sequencing and inter-byte spacing
  always_comb begin
    st_next     = st_reg;
    key_sh_next = key_sh_reg;
    kcnt_next   = kcnt_reg;
    bidx_next   = bidx_reg;
    blen_next   = blen_reg;
    wait_next   = wait_reg;
    unique case (st_reg)
      DPKR_IDLE: begin
        if (key_start && key_info_flag) begin
          st_next   = DPKR_GUARD;
          blen_next = frame_len(key_size);
          bidx_next = '0;
          wait_next = guard_bits;
        end else if (key_start && key_size == `DPKR_SIZE_64) begin
          st_next   = DPKR_KEYIN;
          kcnt_next = '0;
        end
      end
      DPKR_KEYIN: begin
        if (rx_valid) begin
          key_sh_next = {rx_byte, key_sh_reg[63:8]};
          kcnt_next   = kcnt_reg + 4'h1;
          if (kcnt_reg == `DPKR_KEY_BYTES - 4'h1) begin
            st_next = DPKR_IDLE;
          end
        end
      end
      DPKR_GUARD: begin
        if (bit_tick) begin
          if (wait_reg == '0) begin
            st_next = DPKR_SEND;
          end else begin
            wait_next = wait_reg - 3'h1;
          end
        end
      end
      DPKR_SEND: begin
        if (f_ready) begin
          bidx_next = bidx_reg + 5'h1;
          st_next   = (bidx_reg + 5'h1 == blen_reg) ? DPKR_IDLE : DPKR_GAP;
          wait_next = interbyte_delay_enable ? `DPKR_IDLE_BITS + `DPKR_INTERBYTE_DELAY_ENABLE_BITS
                                             : `DPKR_IDLE_BITS;
        end
      end
      DPKR_GAP: begin
        if (bit_tick) begin
          if (wait_reg == 3'h1) begin
            st_next = DPKR_SEND;
          end else begin
            wait_next = wait_reg - 3'h1;
          end
        end
      end
      default: st_next = DPKR_IDLE;
    endcase
    if (break_seen) begin
      st_next = DPKR_IDLE;
    end
  end

  // key flags: bit0 erase, bit1 program, bit2 user row
  logic key_done;
  assign key_done = (st_reg == DPKR_KEYIN) && rx_valid && (kcnt_reg == `DPKR_KEY_BYTES - 4'h1);
  logic [63:0] key_full;
  assign key_full = {rx_byte, key_sh_reg[63:8]};

  always_comb begin
    key_next     = key_state_reg;
    erasing_next = erasing_reg;
    lvl_next     = brownout_level;
    if (port_disable) key_next[0] = 1'b0;
    if (prog_done) key_next[1] = 1'b0;
    if (urow_status_write) key_next[2] = 1'b0;
    // a match in the same cycle as a clear wins; mismatch changes nothing
    if (key_done) begin
      if (key_full == `DPKR_SIG_ERASE) key_next[0] = 1'b1;
      if (key_full == `DPKR_SIG_PROG && !lockbits_set) key_next[1] = 1'b1;
      if (key_full == `DPKR_SIG_UROW && lockbits_set) key_next[2] = 1'b1;
    end
    // done pulse first, so a start in the same cycle still wins
    if (erase_done) erasing_next = 1'b0;
    if (key_state_reg[0] && lockbits_set && !erasing_reg) begin
      erasing_next = 1'b1;
      lvl_next     = bod_fuse_level;
    end
  end

  // repeat counter: count plus one issues, break aborts
  always_comb begin
    rpt_next  = rpt_reg;
    ract_next = repeat_active;
    if (repeat_load) begin
      rpt_next  = repeat_count_value;
      ract_next = 1'b1;
    end else if (repeat_active && instr_done) begin
      if (rpt_reg == 8'h00) ract_next = 1'b0;
      else rpt_next = rpt_reg - 8'h01;
    end
    if (break_seen) ract_next = 1'b0;
  end
  // follow-on issues skip sync and instruction frames
  assign repeat_reissue = repeat_active && instr_done && (rpt_reg != 8'h00) && !break_seen;

  assign lock_state_flag = lockbits_set;
  assign sysbus_allow    = !lockbits_set;
  assign brownout_force  = erasing_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg         <= DPKR_IDLE;
      key_sh_reg     <= '0;
      kcnt_reg       <= '0;
      bidx_reg       <= '0;
      blen_reg       <= '0;
      wait_reg       <= '0;
      key_state_reg  <= '0;
      erasing_reg    <= 1'b0;
      brownout_level <= '0;
      rpt_reg        <= '0;
      repeat_active  <= 1'b0;
    end else if (clk_en) begin
      st_reg         <= st_next;
      key_sh_reg     <= key_sh_next;
      kcnt_reg       <= kcnt_next;
      bidx_reg       <= bidx_next;
      blen_reg       <= blen_next;
      wait_reg       <= wait_next;
      key_state_reg  <= key_next;
      erasing_reg    <= erasing_next;
      brownout_level <= lvl_next;
      rpt_reg        <= rpt_next;
      repeat_active  <= ract_next;
    end
  end

  // output bytes buffered so the line driver may stall the readout
  dpkr_fifo #(.WIDTH(`DPKR_BYTE_W), .DEPTH(`DPKR_FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_data   (sib_byte(system_info_block, bidx_reg)),
    .in_valid  (st_reg == DPKR_SEND),
    .in_ready  (f_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (tx_ready)
  );
  assign tx_byte  = f_data;
  assign tx_valid = f_valid;

  property p_key_silent;
    @(posedge core_clk) disable iff (reset)
      (clk_en && key_done && !f_valid) |=> (!tx_valid [*2]);
  endproperty
  a_key_silent: assert property (p_key_silent) else $error("push during key");

  property p_sysbus;
    @(posedge core_clk) disable iff (reset)
      lockbits_set |-> !sysbus_allow;
  endproperty
  a_sysbus: assert property (p_sysbus) else $error("bus open while locked");

  property p_erase_flag;
    @(posedge core_clk) disable iff (reset)
      (clk_en && key_done && key_full == `DPKR_SIG_ERASE) |=> key_state_reg[0];
  endproperty
  a_erase_flag: assert property (p_erase_flag) else $error("erase key not flagged");

  property p_prog_keep;
    @(posedge core_clk) disable iff (reset)
      (clk_en && key_state_reg[1] && !prog_done) |=> key_state_reg[1];
  endproperty
  a_prog_keep: assert property (p_prog_keep) else $error("program key lost");

  property p_break;
    @(posedge core_clk) disable iff (reset)
      (clk_en && break_seen && !repeat_load) |=> !repeat_active;
  endproperty
  a_break: assert property (p_break) else $error("repeat not aborted");

  property p_guard_first;
    @(posedge core_clk) disable iff (reset)
      (st_reg == DPKR_IDLE && st_next == DPKR_GUARD && clk_en) |=> (wait_reg == $past(guard_bits));
  endproperty
  a_guard_first: assert property (p_guard_first) else $error("guard time wrong");

  property p_len;
    @(posedge core_clk) disable iff (reset)
      (st_reg == DPKR_SEND) |-> (blen_reg == 5'h08 || blen_reg == 5'h10);
  endproperty
  a_len: assert property (p_len) else $error("bad block length");

  property p_urow_lock;
    @(posedge core_clk) disable iff (reset)
      (clk_en && !key_state_reg[2] && !lockbits_set) |=> !key_state_reg[2];
  endproperty
  a_urow_lock: assert property (p_urow_lock) else $error("user row key while unlocked");

  c_sib_read: cover property (@(posedge core_clk) st_reg == DPKR_GAP);
  c_key_prog: cover property (@(posedge core_clk) key_state_reg[1]);
  c_repeat:   cover property (@(posedge core_clk) repeat_reissue);
endmodule

/* File: core/dpkr_fifo.sv */
`timescale 1ns/1ps
module dpkr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // pointer and count next values
  always_comb begin
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset, only written on push
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

/* File: inc/dpkr_cfg.svh */
`ifndef DPKR_CFG_SVH
`define DPKR_CFG_SVH
`define DPKR_SIG_ERASE      64'h4E564D4572617365
`define DPKR_SIG_PROG       64'h4E564D50726F6720
`define DPKR_SIG_UROW       64'h4E564D5573267465
`define DPKR_KEY_BYTES      4'h8
`define DPKR_SIB_FULL_BYTES 5'h10
`define DPKR_SIB_HALF_BYTES 5'h08
`define DPKR_SIZE_64        2'h0
`define DPKR_SIZE_128       2'h1
`define DPKR_IDLE_BITS      3'h2
`define DPKR_INTERBYTE_DELAY_ENABLE_BITS     3'h2
`define DPKR_FIFO_DEPTH     8
`define DPKR_BYTE_W         8
`endif

/* File: inc/dpkr_pkg.sv */
package dpkr_pkg;
  typedef enum logic [4:0] {
    DPKR_IDLE  = 5'h01,
    DPKR_KEYIN = 5'h02,
    DPKR_GUARD = 5'h04,
    DPKR_SEND  = 5'h08,
    DPKR_GAP   = 5'h10
  } dpkr_state_e;
  typedef logic [7:0] dpkr_byte_t;
endpackage

/* File: sim/debug_port_key_and_repeat_bench.sv */
`timescale 1ns/1ps
`include "dpkr_cfg.svh"
module debug_port_key_and_repeat_bench;
  localparam logic [55:0]  FAM = 56'h54535443484950;
  localparam logic [23:0]  MEM = 24'h313030;
  localparam logic [23:0]  DBG = 24'h323031;
  localparam logic [7:0]   OSC = 8'h33;
  localparam logic [127:0] SYSTEM_INFO_BLOCK = {OSC, 8'h00, DBG, MEM, 8'h00, FAM};
  localparam logic [63:0]  BAD = 64'h4E564D4572617366;
  logic       core_clk = 1'b0;
  logic       reset, key_start, key_info_flag, rx_valid, interbyte_delay_enable, repeat_load, stall;
  logic       instr_done, break_seen, port_disable, lockbits_set, prog_done, urow_status_write, erase_done;
  logic       bit_tick, tx_valid, tx_ready, repeat_active, repeat_reissue, lock_state_flag, sysbus_allow;
  logic       brownout_force, clk_en;
  logic [1:0] key_size;
  logic [2:0] guard_bits, bod_fuse_level, key_state_reg, brownout_level;
  logic [7:0] rx_byte, tx_byte, repeat_count_value;
  int         fail_count, checks;
  // 50 MHz core clock
  always #10 core_clk = ~core_clk;
  dpkr_core u_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .key_start(key_start), .key_info_flag(key_info_flag),
    .key_size(key_size), .rx_byte(rx_byte), .rx_valid(rx_valid), .bit_tick(bit_tick), .guard_bits(guard_bits),
    .interbyte_delay_enable(interbyte_delay_enable), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .repeat_load(repeat_load), .repeat_count_value(repeat_count_value), .instr_done(instr_done),
    .break_seen(break_seen), .repeat_active(repeat_active), .repeat_reissue(repeat_reissue),
    .port_disable(port_disable), .lockbits_set(lockbits_set), .prog_done(prog_done),
    .urow_status_write(urow_status_write), .erase_done(erase_done), .bod_fuse_level(bod_fuse_level),
    .key_state_reg(key_state_reg), .lock_state_flag(lock_state_flag), .sysbus_allow(sysbus_allow),
    .brownout_force(brownout_force), .brownout_level(brownout_level), .family_identifier(FAM),
    .memory_ctrl_version(MEM), .debug_logic_version(DBG), .debug_osc_frequency(OSC));
  dpkr_host_model u_host (
    .core_clk(core_clk), .reset(reset), .key_start(key_start), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .stall(stall), .bit_tick(bit_tick), .tx_ready(tx_ready));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // key frames go out least significant byte first
  task automatic key_send(input logic [63:0] sig, input logic [1:0] size);
    @(posedge core_clk);
    key_start <= 1'b1;
    key_info_flag <= 1'b0;
    key_size <= size;
    @(posedge core_clk);
    key_start <= 1'b0;
    rx_valid <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rx_byte <= sig[8*i +: 8];
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    tick(2);
  endtask
  // one pulse on {port_disable, prog_done, urow_status_write, erase_done}
  task automatic ctl(input logic [3:0] v);
    @(posedge core_clk);
    {port_disable, prog_done, urow_status_write, erase_done} <= v;
    @(posedge core_clk);
    {port_disable, prog_done, urow_status_write, erase_done} <= 4'h0;
    tick(2);
  endtask
  // reserved bytes 7 and 14 carry no defined content, so they are skipped
  task automatic sib_read(input logic [1:0] size, input int n);
    u_host.got_byte.delete();
    u_host.got_gap.delete();
    @(posedge core_clk);
    key_start <= 1'b1;
    key_info_flag <= 1'b1;
    key_size <= size;
    @(posedge core_clk);
    key_start <= 1'b0;
    for (int t = 0; t < 3000 && u_host.got_byte.size() < n; t++) @(posedge core_clk);
    tick(40);
    chk(u_host.got_byte.size(), n);
    for (int i = 0; i < n; i++) begin
      if (i != 7 && i != 14) chk(u_host.got_byte[i], SYSTEM_INFO_BLOCK[8*i +: 8]);
    end
  endtask
  task automatic rpt_run(input logic [7:0] n, input int issues, input logic brk);
    int seen;
    seen = 0;
    @(posedge core_clk);
    repeat_load <= 1'b1;
    repeat_count_value <= n;
    @(posedge core_clk);
    repeat_load <= 1'b0;
    for (int i = 0; i < issues; i++) begin
      @(posedge core_clk);
      instr_done <= 1'b1; // one access done, address resent or pointer stepped
      #1;
      if (repeat_reissue === 1'b1) seen++;
      if (i < n) chk(repeat_active, 1'b1);
      @(posedge core_clk);
      instr_done <= 1'b0;
    end
    if (brk) begin
      @(posedge core_clk);
      break_seen <= 1'b1;
      @(posedge core_clk);
      break_seen <= 1'b0;
    end
    tick(2);
    chk(repeat_active, 1'b0);
    chk(seen, brk ? issues : n);
  endtask
  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    {reset, key_start, key_info_flag, rx_valid, interbyte_delay_enable, repeat_load, stall} = 7'h40;
    {instr_done, break_seen, port_disable, lockbits_set, prog_done, urow_status_write, erase_done} = 7'h00;
    {key_size, rx_byte, repeat_count_value, guard_bits} = 21'h0;
    bod_fuse_level = 3'h5;
    clk_en = 1'b1;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    lockbits_set <= 1'b1;
    tick(1);
    chk({key_state_reg, tx_valid, repeat_active, brownout_force}, 6'h00);
    key_send(`DPKR_SIG_ERASE, 2'h1);
    chk(key_state_reg, 3'h0);
    key_send(BAD, 2'h0);
    chk(key_state_reg, 3'h0);
    key_send(`DPKR_SIG_PROG, 2'h0);
    chk(key_state_reg, 3'h0);
    key_send(`DPKR_SIG_UROW, 2'h0);
    chk(key_state_reg, 3'h4);
    key_send(`DPKR_SIG_ERASE, 2'h0);
    chk({key_state_reg, tx_valid}, {3'h5, 1'b0});
    chk({brownout_force, brownout_level, lock_state_flag, sysbus_allow}, 6'h36);
    ctl(4'h2);
    chk(key_state_reg, 3'h1);
    @(posedge core_clk);
    lockbits_set <= 1'b0;
    ctl(4'h1);
    chk({brownout_force, lock_state_flag, sysbus_allow, key_state_reg}, 6'h09);
    key_send(`DPKR_SIG_PROG, 2'h0);
    chk(key_state_reg, 3'h3);
    key_send(`DPKR_SIG_ERASE, 2'h0);
    chk(key_state_reg, 3'h3);
    ctl(4'h8);
    chk(key_state_reg, 3'h2);
    ctl(4'h4);
    chk(key_state_reg, 3'h0);
    $display("key activation test done");
    @(posedge core_clk);
    lockbits_set <= 1'b1;
    guard_bits <= 3'h3;
    sib_read(2'h1, 16);
    for (int i = 0; i < 16; i++) chk(u_host.got_gap[i], i == 0 ? 8'h04 : 8'(`DPKR_IDLE_BITS));
    @(posedge core_clk);
    interbyte_delay_enable <= 1'b1;
    guard_bits <= 3'h1;
    sib_read(2'h0, 8);
    for (int i = 0; i < 8; i++) chk(u_host.got_gap[i], i == 0 ? 8'h02 : 8'h04);
    @(posedge core_clk);
    interbyte_delay_enable <= 1'b0;
    stall <= 1'b1;
    fork
      sib_read(2'h1, 16);
      begin
        tick(300);
        chk(tx_valid, 1'b1);
        @(posedge core_clk);
        stall <= 1'b0;
      end
    join
    chk(tx_valid, 1'b0);
    $display("info block test done");
    rpt_run(8'h02, 3, 1'b0);
    rpt_run(8'h00, 1, 1'b0);
    rpt_run(8'hFF, 2, 1'b1);
    // a load seen while the enable is low must not start a repeat
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat_load <= 1'b1;
    repeat_count_value <= 8'h01;
    @(posedge core_clk);
    repeat_load <= 1'b0;
    clk_en <= 1'b1;
    tick(2);
    chk(repeat_active, 1'b0);
    $display("repeat test done");
    wrap_up();
  end
endmodule

/* File: sim/dpkr_host_model.sv */
`timescale 1ns/1ps
// stand-in debugger: makes bit times, takes readout bytes, may stall
module dpkr_host_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       key_start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  input  wire logic       stall,
  output logic            bit_tick,
  output logic            tx_ready
);
  logic [1:0] div_reg;
  logic [7:0] tick_cnt;
  logic [7:0] got_byte[$];
  logic [7:0] got_gap[$];
  // a slow host only holds ready low, so bytes wait in the buffer
  assign tx_ready = !stall;
  // four core clocks per bit keeps readouts short; a slow sync rate only stretches it
  always @(posedge core_clk) begin
    div_reg  <= reset ? 2'h0 : div_reg + 2'h1;
    bit_tick <= !reset && div_reg == 2'h3;
  end
  // idle bits counted since the request or the previous byte
  always @(posedge core_clk) begin
    if (key_start || (tx_valid && tx_ready)) begin
      tick_cnt <= 8'h00;
    end else if (bit_tick) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
    if (tx_valid && tx_ready) begin
      got_byte.push_back(tx_byte);
      got_gap.push_back(tick_cnt);
    end
  end
endmodule
